// File: rtl/tma_hash.sv
// Primary and secondary page-group address former
`timescale 1ns/10ps
module tma_hash (
    input  wire logic [31:0] miss_addr,
    input  wire logic [23:0] virtual_segment_identifier,
    input  wire logic [6:0]  org_hi,
    input  wire logic [8:0]  org_mask,
    output logic      [31:0] prim_addr,
    output logic      [31:0] sec_addr
);
    import tma_pkg::*;

    logic [18:0] hash_pri;
    logic [18:0] hash_sec;
    logic [18:0] h_prim;
    logic [18:0] h_sec;

    // ********************************************************
    // Hash of segment id and page index
    // ********************************************************
    always_comb
    begin
        hash_pri = virtual_segment_identifier[18:0] ^ {3'h0, miss_addr[27:12]};
        hash_sec = ~hash_pri;
        h_prim   = {hash_pri[18:10] & org_mask, hash_pri[9:0]};
        h_sec    = {hash_sec[18:10] & org_mask, hash_sec[9:0]};
    end

    // Only the hashed field differs between the two
    assign prim_addr = {org_hi, h_prim, {TMA_GRP_ZERO_W{1'b0}}};
    assign sec_addr  = {org_hi, h_sec, {TMA_GRP_ZERO_W{1'b0}}};

endmodule // tma_hash

// File: rtl/tma_regs.sv
// TLB miss-assist registers and TLB entry load merge
`timescale 1ns/10ps
module tma_regs (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               miss_req,
    input  wire tma_pkg::tma_miss_t miss_kind,
    input  wire logic [31:0]        miss_ea,
    input  wire logic               little_endian,
    input  wire logic [23:0]        seg_virtual_segment_identifier,
    input  wire logic               seg_key_super,
    input  wire logic               seg_key_user,
    input  wire logic               problem_state,
    input  wire logic               lru_way,
    input  wire logic [3:0]         cr0_bits,
    input  wire logic               older_pending,
    input  wire logic               dtlb_hit,
    input  wire logic               dtlb_changed,
    input  wire logic               store_access,
    input  wire logic [15:0]        sdr_org,
    input  wire logic [8:0]         sdr_mask,
    input  wire logic               spr_rd,
    input  wire logic               spr_wr,
    input  wire logic [9:0]         spr_num,
    input  wire logic [31:0]        spr_wdata,
    input  wire logic               srr_way_wr,
    input  wire logic               srr_way_val,
    input  wire logic               tlb_load,
    input  wire logic               tlb_load_instr,
    input  wire logic [31:0]        tlb_load_ea,
    output logic [31:0]             spr_rdata,
    output logic                    priv_exc,
    output logic                    store_miss_cond,
    output logic                    miss_exc,
    output tma_pkg::tma_miss_t      miss_exc_kind,
    output logic [31:0]             srr_status,
    output logic                    tlb_we_instr,
    output logic                    tlb_we_data,
    output logic [4:0]              tlb_index,
    output logic                    tlb_way,
    output logic [31:0]             tlb_word1,
    output logic [31:0]             tlb_word2,
    output logic [19:0]             tlb_epn
);
    import tma_pkg::*;

    logic [31:0] dmiss_q;
    logic [31:0] imiss_q;
    logic [31:0] data_pte_compare_q;
    logic [31:0] instr_pte_compare_q;
    logic [31:0] pte2_q;
    logic [31:0] srr_q;
    logic        pend_q;
    tma_miss_t   kind_q;
    logic [31:0] ea_q;
    logic [23:0] virtual_segment_identifier_q;
    logic        key_q;
    logic        way_q;
    logic [3:0]  cr_q;
    logic        exc_q;
    logic [31:0] ea_be;
    logic [31:0] cmp_d;
    logic [31:0] grp_src;
    logic [23:0] grp_virtual_segment_identifier;
    logic [31:0] prim_w;
    logic [31:0] sec_w;
    logic        we_i_q;
    logic        we_d_q;

    // ********************************************************
    // Miss detection and exception sequencing
    // ********************************************************
    assign store_miss_cond = store_access
                           & (~dtlb_hit | (dtlb_hit & ~dtlb_changed));

    // Byte-swap a little-endian data address back to big-endian order
    assign ea_be = (little_endian && miss_kind != TMA_MISS_INSTR)
                 ? {miss_ea[31:3], miss_ea[2:0] ^ 3'h7}
                 : miss_ea;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_q <= 1'b0;
            kind_q <= TMA_MISS_INSTR;
            ea_q   <= TMA_RESET_VAL;
            virtual_segment_identifier_q <= 24'h000000;
            key_q  <= 1'b0;
            way_q  <= 1'b0;
            cr_q   <= 4'h0;
        end
        else if (miss_req && !pend_q)
        begin
            pend_q <= 1'b1;
            kind_q <= miss_kind;
            ea_q   <= ea_be;
            virtual_segment_identifier_q <= seg_virtual_segment_identifier;
            key_q  <= problem_state ? seg_key_user : seg_key_super;
            way_q  <= lru_way;
            cr_q   <= cr0_bits;
        end
        else if (pend_q && !older_pending)
        begin
            pend_q <= 1'b0;
        end
    end

    assign exc_q = pend_q && !older_pending;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            miss_exc      <= 1'b0;
            miss_exc_kind <= TMA_MISS_INSTR;
        end
        else
        begin
            miss_exc      <= exc_q;
            miss_exc_kind <= kind_q;
        end
    end

    // ********************************************************
    // Miss address and compare capture
    // ********************************************************
    always_comb
    begin
        cmp_d = TMA_RESET_VAL;
        cmp_d[TMA_CMP_VALID_BIT] = 1'b1;
        cmp_d[TMA_CMP_VIRTUAL_SEGMENT_IDENTIFIER_HI:TMA_CMP_VIRTUAL_SEGMENT_IDENTIFIER_LO] = virtual_segment_identifier_q;
        cmp_d[TMA_CMP_HASH_BIT] = 1'b0;
        cmp_d[TMA_CMP_API_HI:0] = ea_q[27:22];
    end

    // Only the miss path writes these; software writes never land
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dmiss_q <= TMA_RESET_VAL;
            imiss_q <= TMA_RESET_VAL;
            data_pte_compare_q  <= TMA_RESET_VAL;
            instr_pte_compare_q  <= TMA_RESET_VAL;
        end
        else if (exc_q)
        begin
            if (kind_q == TMA_MISS_INSTR)
            begin
                imiss_q <= ea_q;
                instr_pte_compare_q  <= cmp_d;
            end
            else
            begin
                dmiss_q <= ea_q;
                data_pte_compare_q  <= cmp_d;
            end
        end
    end

    // ********************************************************
    // Save/restore status
    // ********************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            srr_q <= TMA_RESET_VAL;
        end
        else if (exc_q)
        begin
            srr_q                    <= TMA_RESET_VAL;
            srr_q[31:28]             <= cr_q;
            srr_q[TMA_SRR_KEY_BIT]   <= key_q;
            srr_q[TMA_SRR_IMISS_BIT] <= kind_q == TMA_MISS_INSTR;
            srr_q[TMA_SRR_WAY_BIT]   <= way_q;
            srr_q[TMA_SRR_LOAD_BIT]  <= kind_q == TMA_MISS_LOAD;
        end
        else if (srr_way_wr)
        begin
            srr_q[TMA_SRR_WAY_BIT] <= srr_way_val;
        end
    end

    assign srr_status = srr_q;

    // ********************************************************
    // Page-group addresses
    // ********************************************************
    assign grp_src  = (srr_q[TMA_SRR_IMISS_BIT]) ? imiss_q : dmiss_q;
    assign grp_virtual_segment_identifier = (srr_q[TMA_SRR_IMISS_BIT])
                    ? instr_pte_compare_q[TMA_CMP_VIRTUAL_SEGMENT_IDENTIFIER_HI:TMA_CMP_VIRTUAL_SEGMENT_IDENTIFIER_LO]
                    : data_pte_compare_q[TMA_CMP_VIRTUAL_SEGMENT_IDENTIFIER_HI:TMA_CMP_VIRTUAL_SEGMENT_IDENTIFIER_LO];

    tma_hash u_hash (
        .miss_addr (grp_src),
        .virtual_segment_identifier      (grp_virtual_segment_identifier),
        .org_hi    (sdr_org[15:9]),
        .org_mask  (sdr_mask),
        .prim_addr (prim_w),
        .sec_addr  (sec_w)
    );

    // ********************************************************
    // Second-word register and register port
    // ********************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pte2_q <= TMA_RESET_VAL;
        end
        else if (spr_wr && !problem_state && spr_num == TMA_SPR_PTE_WORD2)
        begin
            pte2_q <= spr_wdata & TMA_PTE2_WMASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            priv_exc <= 1'b0;
        end
        else
        begin
            priv_exc <= (spr_rd || spr_wr) && problem_state && (
                spr_num == TMA_SPR_DMISS_ADDR || spr_num == TMA_SPR_DATA_PTE_COMPARE ||
                spr_num == TMA_SPR_PRIM_GRP || spr_num == TMA_SPR_SEC_GRP ||
                spr_num == TMA_SPR_IMISS_ADDR || spr_num == TMA_SPR_INSTR_PTE_COMPARE ||
                spr_num == TMA_SPR_PTE_WORD2);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            spr_rdata <= TMA_RESET_VAL;
        end
        else if (spr_rd && !problem_state)
        begin
            case (spr_num)
                TMA_SPR_DMISS_ADDR: spr_rdata <= dmiss_q;
                TMA_SPR_IMISS_ADDR: spr_rdata <= imiss_q;
                TMA_SPR_DATA_PTE_COMPARE:       spr_rdata <= data_pte_compare_q;
                TMA_SPR_INSTR_PTE_COMPARE:       spr_rdata <= instr_pte_compare_q;
                TMA_SPR_PRIM_GRP:   spr_rdata <= prim_w;
                TMA_SPR_SEC_GRP:    spr_rdata <= sec_w;
                TMA_SPR_PTE_WORD2:  spr_rdata <= pte2_q;
                default:            spr_rdata <= TMA_RESET_VAL;
            endcase
        end
    end

    // ********************************************************
    // TLB entry load
    // ********************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            we_i_q    <= 1'b0;
            we_d_q    <= 1'b0;
            tlb_index <= 5'h00;
            tlb_way   <= 1'b0;
            tlb_word1 <= TMA_RESET_VAL;
            tlb_word2 <= TMA_RESET_VAL;
            tlb_epn   <= 20'h00000;
        end
        else
        begin
            we_i_q <= tlb_load && tlb_load_instr;
            we_d_q <= tlb_load && !tlb_load_instr;
            if (tlb_load)
            begin
                tlb_index <= tlb_load_ea[16:12];
                tlb_way   <= srr_q[TMA_SRR_WAY_BIT];
                tlb_word1 <= tlb_load_instr ? instr_pte_compare_q : data_pte_compare_q;
                tlb_word2 <= pte2_q;
                tlb_epn   <= tlb_load_instr ? imiss_q[31:12]
                                            : dmiss_q[31:12];
            end
        end
    end

    assign tlb_we_instr = we_i_q;
    assign tlb_we_data  = we_d_q;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence miss_taken_s;
        exc_q && kind_q != TMA_MISS_INSTR;
    endsequence

    cmp_valid_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        exc_q |=> data_pte_compare_q[TMA_CMP_VALID_BIT] || instr_pte_compare_q[TMA_CMP_VALID_BIT])
        else $error("compare valid not set after miss");
    cmp_hash_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        miss_taken_s |=> !data_pte_compare_q[TMA_CMP_HASH_BIT])
        else $error("compare hash bit not cleared");
    dmiss_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
        miss_taken_s |=> dmiss_q == $past(ea_q))
        else $error("data miss address not captured");
    miss_ro_a: assert property (@(posedge clk) disable iff (!rst_b)
        !exc_q |=> $stable(dmiss_q) && $stable(imiss_q))
        else $error("miss address changed without miss");
    grp_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        prim_w[5:0] == 6'h00 && sec_w[5:0] == 6'h00)
        else $error("group address low bits nonzero");
    grp_org_a: assert property (@(posedge clk) disable iff (!rst_b)
        prim_w[31:25] == sdr_org[15:9] && sec_w[31:25] == prim_w[31:25])
        else $error("group origin bits wrong");
    srr_flags_a: assert property (@(posedge clk) disable iff (!rst_b)
        exc_q |=> srr_q[TMA_SRR_WAY_BIT] == $past(way_q)
              && srr_q[TMA_SRR_IMISS_BIT] == ($past(kind_q) == TMA_MISS_INSTR))
        else $error("save status flags wrong");
    tlb_merge_a: assert property (@(posedge clk) disable iff (!rst_b)
        tlb_load && !tlb_load_instr |=> tlb_we_data
            && tlb_word1 == $past(data_pte_compare_q) && tlb_word2 == $past(pte2_q))
        else $error("data TLB load merge wrong");
    user_priv_a: assert property (@(posedge clk) disable iff (!rst_b)
        spr_wr && problem_state && spr_num == TMA_SPR_PTE_WORD2
            |=> priv_exc && $stable(pte2_q))
        else $error("user access not refused");
    pte2_resv_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pte2_q & ~TMA_PTE2_WMASK) == TMA_RESET_VAL)
        else $error("second word reserved bits set");

endmodule // tma_regs

// File: shared/tma_pkg.sv
// Constants and types of the TLB miss-assist register block
package tma_pkg;

    // ********************************************************
    // Special-register numbers on the core's register port
    // ********************************************************
    localparam logic [9:0] TMA_SPR_DMISS_ADDR = 10'h3F0;
    localparam logic [9:0] TMA_SPR_DATA_PTE_COMPARE       = 10'h3F1;
    localparam logic [9:0] TMA_SPR_PRIM_GRP   = 10'h3F2;
    localparam logic [9:0] TMA_SPR_SEC_GRP    = 10'h3F3;
    localparam logic [9:0] TMA_SPR_IMISS_ADDR = 10'h3F4;
    localparam logic [9:0] TMA_SPR_INSTR_PTE_COMPARE       = 10'h3F5;
    localparam logic [9:0] TMA_SPR_PTE_WORD2  = 10'h3FA;

    // ********************************************************
    // Field positions, little-endian bit index (doc bit b = 31-b)
    // ********************************************************
    localparam int TMA_CMP_VALID_BIT = 31;
    localparam int TMA_CMP_VIRTUAL_SEGMENT_IDENTIFIER_HI   = 30;
    localparam int TMA_CMP_VIRTUAL_SEGMENT_IDENTIFIER_LO   = 7;
    localparam int TMA_CMP_HASH_BIT  = 6;
    localparam int TMA_CMP_API_HI    = 5;
    localparam int TMA_GRP_ORG_HI    = 31;
    localparam int TMA_GRP_ORG_LO    = 25;
    localparam int TMA_GRP_HASH_HI   = 24;
    localparam int TMA_GRP_HASH_LO   = 6;
    localparam int TMA_GRP_ZERO_W    = 6;
    localparam int TMA_SRR_KEY_BIT   = 19;
    localparam int TMA_SRR_IMISS_BIT = 18;
    localparam int TMA_SRR_WAY_BIT   = 17;
    localparam int TMA_SRR_LOAD_BIT  = 16;

    // Second-word register: reserved bits 20-22 and 29 read zero
    localparam logic [31:0] TMA_PTE2_WMASK = 32'hFFFFF1FB;
    localparam logic [31:0] TMA_RESET_VAL  = 32'h00000000;

    // Miss kinds
    typedef enum logic [1:0] {
        TMA_MISS_INSTR,
        TMA_MISS_LOAD,
        TMA_MISS_STORE
    } tma_miss_t;

endpackage

// File: verif/tma_core_model.sv
// Partner model: core drain timing and TLB entry arrays
`timescale 1ns/10ps
module tma_core_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        miss_req,
    input  wire logic [3:0]  drain_len,
    input  wire logic        tlb_we_instr,
    input  wire logic        tlb_we_data,
    input  wire logic [4:0]  tlb_index,
    input  wire logic        tlb_way,
    input  wire logic [31:0] tlb_word1,
    input  wire logic [31:0] tlb_word2,
    output logic             older_pending
);
    logic [3:0]  cnt_q;
    logic [63:0] entry_q [0:127];
    assign older_pending = (cnt_q != 4'h0);
    // Older instructions drain a set time after a miss
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 4'h0;
        else if (miss_req && cnt_q == 4'h0)
            cnt_q <= drain_len;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end
    // Entries kept by side, way and set
    always_ff @(posedge clk)
    begin
        if (tlb_we_instr || tlb_we_data)
            entry_q[{tlb_we_instr, tlb_way, tlb_index}] <=
                {tlb_word1, tlb_word2};
    end
endmodule // tma_core_model

// File: verif/tma_regs_test.sv
// Self-checking bench of the TLB miss-assist registers
`timescale 1ns/10ps
module tma_regs_test;
    import tma_pkg::*;
    typedef struct {
        logic [1:0]  w;
        logic [31:0] a, m, b, c;
    } tma_note_t;
    logic        clk, rst_b, miss_req, little_endian, seg_key_super;
    logic        seg_key_user, problem_state, lru_way, dtlb_hit;
    logic        dtlb_changed, store_access, spr_rd, spr_wr, srr_way_wr;
    logic        srr_way_val, tlb_load, tlb_load_instr, rd_taken;
    logic        older_pending, priv_exc, store_miss_cond, miss_exc;
    logic        tlb_we_instr, tlb_we_data, tlb_way;
    tma_miss_t   miss_kind, miss_exc_kind;
    logic [31:0] miss_ea, spr_wdata, tlb_load_ea, spr_rdata, srr_status;
    logic [31:0] tlb_word1, tlb_word2;
    logic [23:0] seg_virtual_segment_identifier;
    logic [15:0] sdr_org;
    logic [8:0]  sdr_mask;
    logic [9:0]  spr_num;
    logic [4:0]  tlb_index;
    logic [19:0] tlb_epn;
    logic [3:0]  cr0_bits, drain_len;
    tma_note_t   notes [$];
    int          err_count, compares, cycles;

    tma_regs dut_u (.*);
    tma_core_model model_u (.*);

    always #12.5 clk = ~clk;

    task automatic flag(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic give_verdict;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic note(input logic [1:0] w, input logic [31:0] a, m, b, c);
        notes.push_back('{w, a, m, b, c});
    endtask

    // ******************************
    // Result watcher
    // ******************************
    task automatic take(input logic [1:0] w, input logic [31:0] a, b, c);
        tma_note_t n;
        if (notes.size() == 0)
        begin
            flag(1'b0, "result with nothing awaited");
        end
        else
        begin
            n = notes.pop_front();
            flag(n.w === w && (a & n.m) === (n.a & n.m) && b === n.b
                 && c === n.c, "result differs from expectation");
        end
    endtask

    always @(posedge clk)
    begin
        rd_taken <= spr_rd && !problem_state;
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            give_verdict;
        end
    end

    always @(negedge clk)
    begin
        if (miss_exc)
            take(2'h0, srr_status, {30'h0, miss_exc_kind}, 32'h0);
        if (rd_taken)
            take(2'h1, spr_rdata, 32'h0, 32'h0);
        if (tlb_we_instr || tlb_we_data)
            take(2'h2, tlb_word1, tlb_word2,
                 {tlb_epn, 5'h0, tlb_we_instr, tlb_way, tlb_index});
        if (priv_exc)
            take(2'h3, 32'h0, 32'h0, 32'h0);
    end

    // ******************************
    // Drivers
    // ******************************
    task automatic rd(input logic [9:0] n, input logic [31:0] e, m);
        note(problem_state ? 2'h3 : 2'h1, problem_state ? 32'h0 : e, m,
             32'h0, 32'h0);
        @(negedge clk);
        spr_num = n;
        spr_rd = 1'b1;
        @(negedge clk);
        spr_rd = 1'b0;
    endtask

    task automatic wr(input logic [9:0] n, input logic [31:0] d);
        if (problem_state)
            note(2'h3, 32'h0, 32'h0, 32'h0, 32'h0);
        @(negedge clk);
        spr_num = n;
        spr_wdata = d;
        spr_wr = 1'b1;
        @(negedge clk);
        spr_wr = 1'b0;
    endtask

    task automatic settle;
        for (int i = 0; i < 40 && notes.size() != 0; i++)
            @(posedge clk);
        flag(notes.size() == 0, "awaited result never came");
        notes.delete();
    endtask

    // ******************************
    // Miss, register read-back and entry load
    // ******************************
    task automatic miss(input tma_miss_t k, input logic [3:0] dl);
        logic [31:0] s, cap, cv, pte;
        logic [18:0] h;
        logic        ins, way;
        @(negedge clk);
        {miss_ea, seg_virtual_segment_identifier, sdr_org} = {$urandom, $urandom, $urandom};
        {little_endian, seg_key_super, seg_key_user} = $urandom;
        {problem_state, lru_way, cr0_bits, sdr_mask} = $urandom;
        ins = (k == TMA_MISS_INSTR);
        s = {cr0_bits, 28'h0};
        s[TMA_SRR_KEY_BIT] = problem_state ? seg_key_user : seg_key_super;
        s[TMA_SRR_IMISS_BIT] = ins;
        s[TMA_SRR_WAY_BIT] = lru_way;
        s[TMA_SRR_LOAD_BIT] = (k == TMA_MISS_LOAD);
        note(2'h0, s, 32'hF00F0000, {30'h0, k}, 32'h0);
        miss_kind = k;
        drain_len = dl;
        miss_req = 1'b1;
        repeat ((dl != 4'h0) ? 3 : 1) @(negedge clk);
        miss_req = 1'b0;
        settle();
        problem_state = 1'b0;
        cap = (!ins && little_endian) ? miss_ea ^ 32'h7 : miss_ea;
        cv = {1'b1, seg_virtual_segment_identifier, 1'b0, cap[27:22]};
        rd(ins ? TMA_SPR_IMISS_ADDR : TMA_SPR_DMISS_ADDR, cap, '1);
        rd(ins ? TMA_SPR_INSTR_PTE_COMPARE : TMA_SPR_DATA_PTE_COMPARE, cv, '1);
        h = seg_virtual_segment_identifier[18:0] ^ {3'h0, cap[27:12]};
        rd(TMA_SPR_PRIM_GRP, {sdr_org[15:9], h[18:10] & sdr_mask, h[9:0],
           6'h00}, '1);
        rd(TMA_SPR_SEC_GRP, {sdr_org[15:9], ~h[18:10] & sdr_mask, ~h[9:0],
           6'h00}, '1);
        wr(ins ? TMA_SPR_IMISS_ADDR : TMA_SPR_DMISS_ADDR, ~cap);
        rd(ins ? TMA_SPR_IMISS_ADDR : TMA_SPR_DMISS_ADDR, cap, '1);
        pte = $urandom;
        if (k == TMA_MISS_STORE)
            pte[7] = 1'b1;
        wr(TMA_SPR_PTE_WORD2, pte);
        rd(TMA_SPR_PTE_WORD2, pte & TMA_PTE2_WMASK, '1);
        settle();
        way = lru_way;
        @(negedge clk);
        if (k == TMA_MISS_STORE)
        begin
            way = ~lru_way;
            {srr_way_wr, srr_way_val} = {1'b1, way};
            @(negedge clk);
            srr_way_wr = 1'b0;
        end
        note(2'h2, cv, '1, pte & TMA_PTE2_WMASK,
             {cap[31:12], 5'h0, ins, way, cap[16:12]});
        {tlb_load, tlb_load_instr, tlb_load_ea} = {1'b1, ins, cap};
        @(negedge clk);
        tlb_load = 1'b0;
        settle();
    endtask

    initial
    begin
        {clk, rst_b, miss_req, little_endian, seg_key_super} = '0;
        {seg_key_user, problem_state, lru_way, dtlb_hit, dtlb_changed} = '0;
        {store_access, spr_rd, spr_wr, srr_way_wr, srr_way_val} = '0;
        {tlb_load, tlb_load_instr, miss_ea, spr_wdata, tlb_load_ea} = '0;
        {seg_virtual_segment_identifier, sdr_org, sdr_mask, spr_num, cr0_bits, drain_len} = '0;
        miss_kind = TMA_MISS_INSTR;
        void'($urandom(63692));
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        flag(srr_status === 32'h0 && spr_rdata === 32'h0, "reset value");
        miss(TMA_MISS_INSTR, 4'h0);
        miss(TMA_MISS_LOAD, 4'h5);
        miss(TMA_MISS_STORE, 4'h4);
        problem_state = 1'b1;
        rd(TMA_SPR_PTE_WORD2, 32'h0, 32'h0);
        wr(TMA_SPR_PTE_WORD2, 32'hFFFFFFFF);
        settle();
        problem_state = 1'b0;
        rd(10'h000, 32'h0, '1);
        settle();
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            {dtlb_hit, dtlb_changed, store_access} = i[2:0];
            #1;
            flag(store_miss_cond === (store_access &&
                 !(dtlb_hit && dtlb_changed)), "store miss cond");
        end
        give_verdict;
    end
endmodule // tma_regs_test
